// ==== hdl/cic_pkg.sv ====
// ---------------------------------------------------------------------------
// constants and carriers for the core interrupt control block
// ---------------------------------------------------------------------------
package cic_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 8;

  // interrupt_control is mirrored in all four data-memory banks
  localparam logic [ADDR_W-1:0] IC_ADDR_BANK0 = 9'h00b;
  localparam logic [ADDR_W-1:0] IC_ADDR_BANK1 = 9'h08b;
  localparam logic [ADDR_W-1:0] IC_ADDR_BANK2 = 9'h10b;
  localparam logic [ADDR_W-1:0] IC_ADDR_BANK3 = 9'h18b;
  // per_pin_change_enable register
  localparam logic [ADDR_W-1:0] IOC_ADDR      = 9'h096;

  // interrupt_control field positions
  localparam int unsigned GLOBAL_IRQ_ENABLE_BIT     = 7;
  localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int unsigned TIMER_IRQ_ENABLE_BIT      = 5;
  localparam int unsigned EXT_PIN_IRQ_ENABLE_BIT    = 4;
  localparam int unsigned PORT_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int unsigned TIMER_FLAG_BIT            = 2;
  localparam int unsigned EXT_PIN_FLAG_BIT          = 1;
  localparam int unsigned PORT_CHANGE_FLAG_BIT      = 0;

  // reset values
  localparam logic [DATA_W-1:0] IC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] IOC_RESET = 8'hf0;
  localparam logic [DATA_W-1:0] RD_IDLE   = 8'h00;

  // register port request, as issued by the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cic_bus_req_s;

  // event sources: timer and pin events feed the flags, peripheral pending goes straight to the request
  typedef struct packed {
    logic              timer_overflow;
    logic              ext_pin_edge;
    logic              periph_pending;
  } cic_events_s;

endpackage

// ==== hdl/cic_port_change.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// port-b change detector: one-cycle pulse when an enabled pin moves
// ---------------------------------------------------------------------------
module cic_port_change (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // pins and per-pin enables
  input  wire logic [cic_pkg::PORT_W-1:0] port_b_pins,
  input  wire logic [cic_pkg::PORT_W-1:0] per_pin_change_enable,
  // change event
  output logic                            change_pulse
);

  logic [cic_pkg::PORT_W-1:0] last_pins;
  logic [cic_pkg::PORT_W-1:0] pin_moved;
  logic                       primed;
  logic                       next_primed;
  logic                       next_change_pulse;

  // per pin compare, gated by its own enable
  genvar i;
  generate
    for (i = 0; i < cic_pkg::PORT_W; i++) begin : g_pin
      assign pin_moved[i] = primed && per_pin_change_enable[i]
                            && (port_b_pins[i] != last_pins[i]); // RULE_10
    end
  endgenerate

  // the first sample after reset only loads the reference, so no false edge
  always_comb begin
    next_primed       = 1'b1;
    next_change_pulse = |pin_moved;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_pins    <= '0;
      primed       <= 1'b0;
      change_pulse <= 1'b0;
    end else begin
      last_pins    <= port_b_pins;
      primed       <= next_primed;
      change_pulse <= next_change_pulse;
    end
  end

  // a move on a disabled pin alone never raises the event
  property p_masked_pin;
    @(posedge mclk) disable iff (reset)
      (primed && ((port_b_pins ^ last_pins) & per_pin_change_enable) == '0)
      |=> !change_pulse;
  endproperty
  a_masked_pin: assert property (p_masked_pin) else $error("masked pin change raised event"); // RULE_10

  // an enabled pin move gives the event one cycle later
  property p_enabled_pin;
    @(posedge mclk) disable iff (reset)
      (primed && ((port_b_pins ^ last_pins) & per_pin_change_enable) != '0)
      |=> change_pulse;
  endproperty
  a_enabled_pin: assert property (p_enabled_pin) else $error("enabled pin change lost"); // RULE_07

endmodule

// ==== hdl/cic_core.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// core interrupt control
// ---------------------------------------------------------------------------
// Overview of operation
// RULE_01 - flags set regardless of any enable bit
// RULE_02 - bit 7 global enable gates every interrupt
// RULE_03 - bit 6 gates the peripheral interrupt group
// RULE_04 - bit 5 enables the timer overflow interrupt
// RULE_05 - bit 2 timer flag, sticky until software clears
// RULE_06 - bit 4 pin enable, bit 1 pin flag
// RULE_07 - bit 3 change enable, bit 0 change flag
// RULE_08 - software clears stale flag before enabling
// RULE_09 - register shared by all four bank mirrors
// RULE_10 - each pin needs its own change enable
// RULE_11 - request when global, flag and enable agree
// RULE_12 - reset clears enables and timer, pin flags
module cic_core (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // register port
  input  wire cic_pkg::cic_bus_req_s       bus_req,
  output logic [cic_pkg::DATA_W-1:0]       rdata,
  // event sources
  input  wire cic_pkg::cic_events_s        events,
  input  wire logic [cic_pkg::PORT_W-1:0]  port_b_pins,
  // request to the core
  output logic                             irq_request,
  output logic [cic_pkg::DATA_W-1:0]       interrupt_control
);

  // ---------------------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------------------
  logic [cic_pkg::DATA_W-1:0] per_pin_change_enable;
  logic [cic_pkg::DATA_W-1:0] next_interrupt_control;
  logic [cic_pkg::DATA_W-1:0] next_per_pin_change_enable;
  logic [cic_pkg::DATA_W-1:0] next_rdata;
  logic                       next_irq_request;
  logic                       port_change_pulse;
  logic                       hit_ic;
  logic                       hit_ioc;
  logic [cic_pkg::DATA_W-1:0] flag_set;

  // named views of the control fields
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic timer_overflow_irq_enable;
  logic ext_pin_irq_enable;
  logic port_change_irq_enable;
  logic timer_overflow_flag;
  logic ext_pin_flag;
  logic port_change_flag;

  assign global_irq_enable         = interrupt_control[cic_pkg::GLOBAL_IRQ_ENABLE_BIT];
  assign peripheral_irq_enable     = interrupt_control[cic_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
  assign timer_overflow_irq_enable = interrupt_control[cic_pkg::TIMER_IRQ_ENABLE_BIT];
  assign ext_pin_irq_enable        = interrupt_control[cic_pkg::EXT_PIN_IRQ_ENABLE_BIT];
  assign port_change_irq_enable    = interrupt_control[cic_pkg::PORT_CHANGE_IRQ_ENABLE_BIT];
  assign timer_overflow_flag       = interrupt_control[cic_pkg::TIMER_FLAG_BIT];
  assign ext_pin_flag              = interrupt_control[cic_pkg::EXT_PIN_FLAG_BIT];
  assign port_change_flag          = interrupt_control[cic_pkg::PORT_CHANGE_FLAG_BIT];

  // any of the four bank mirrors reaches the same storage
  assign hit_ic  = (bus_req.addr == cic_pkg::IC_ADDR_BANK0)
                || (bus_req.addr == cic_pkg::IC_ADDR_BANK1)
                || (bus_req.addr == cic_pkg::IC_ADDR_BANK2)
                || (bus_req.addr == cic_pkg::IC_ADDR_BANK3); // RULE_09
  assign hit_ioc = (bus_req.addr == cic_pkg::IOC_ADDR);

  // ---------------------------------------------------------------------------
  // port change detection
  // ---------------------------------------------------------------------------
  cic_port_change u_port_change (
    .mclk                  (mclk),
    .reset                 (reset),
    .port_b_pins           (port_b_pins),
    .per_pin_change_enable (per_pin_change_enable),
    .change_pulse          (port_change_pulse)
  );

  // ---------------------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------------------
  // hardware set bits; enables do not gate them, so software sees events even
  // while polling with interrupts off
  always_comb begin
    flag_set = '0;
    flag_set[cic_pkg::TIMER_FLAG_BIT]       = events.timer_overflow; // RULE_05
    flag_set[cic_pkg::EXT_PIN_FLAG_BIT]     = events.ext_pin_edge;   // RULE_06
    flag_set[cic_pkg::PORT_CHANGE_FLAG_BIT] = port_change_pulse;     // RULE_07
  end

  // a write replaces the byte, but a same-cycle event still sets its flag
  always_comb begin
    next_interrupt_control = interrupt_control | flag_set; // RULE_01
    if (bus_req.wr && hit_ic) begin
      next_interrupt_control = bus_req.wdata | flag_set; // RULE_09
    end
  end

  // per-pin enables are plain read/write storage
  always_comb begin
    next_per_pin_change_enable = per_pin_change_enable;
    if (bus_req.wr && hit_ioc) begin
      next_per_pin_change_enable = bus_req.wdata; // RULE_10
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_comb begin
    next_rdata = cic_pkg::RD_IDLE;
    if (bus_req.rd && hit_ic) begin
      next_rdata = interrupt_control;
    end else if (bus_req.rd && hit_ioc) begin
      next_rdata = per_pin_change_enable;
    end
  end

  // ---------------------------------------------------------------------------
  // request to the core
  // ---------------------------------------------------------------------------
  // peripheral pending arrives already flagged and masked by its own enables;
  // registered so the output is glitch free, at the cost of one cycle
  always_comb begin
    next_irq_request = global_irq_enable && (                    // RULE_02
        (timer_overflow_irq_enable && timer_overflow_flag)        // RULE_04
     || (ext_pin_irq_enable && ext_pin_flag)                      // RULE_06
     || (port_change_irq_enable && port_change_flag)              // RULE_07
     || (peripheral_irq_enable && events.periph_pending));        // RULE_03 RULE_11
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  // the change flag is nominally unknown after reset; zero keeps sims clean
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      interrupt_control     <= cic_pkg::IC_RESET; // RULE_12
      per_pin_change_enable <= cic_pkg::IOC_RESET;
      rdata                 <= cic_pkg::RD_IDLE;
      irq_request           <= 1'b0;
    end else begin
      interrupt_control     <= next_interrupt_control;
      per_pin_change_enable <= next_per_pin_change_enable;
      rdata                 <= next_rdata;
      irq_request           <= next_irq_request;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_timer_flag_set;
    @(posedge mclk) disable iff (reset)
      events.timer_overflow |=> interrupt_control[cic_pkg::TIMER_FLAG_BIT];
  endproperty
  a_timer_flag_set: assert property (p_timer_flag_set) else $error("timer flag not set"); // RULE_05

  // flags set even with every enable clear, including during a clearing write
  property p_ext_flag_set;
    @(posedge mclk) disable iff (reset)
      events.ext_pin_edge |=> interrupt_control[cic_pkg::EXT_PIN_FLAG_BIT];
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set) else $error("pin flag not set"); // RULE_01

  property p_change_flag_set;
    @(posedge mclk) disable iff (reset)
      port_change_pulse |=> interrupt_control[cic_pkg::PORT_CHANGE_FLAG_BIT];
  endproperty
  a_change_flag_set: assert property (p_change_flag_set) else $error("change flag not set"); // RULE_07

  // sticky: only a write drops a flag
  property p_timer_sticky;
    @(posedge mclk) disable iff (reset)
      (interrupt_control[cic_pkg::TIMER_FLAG_BIT] && !(bus_req.wr && hit_ic))
      |=> interrupt_control[cic_pkg::TIMER_FLAG_BIT];
  endproperty
  a_timer_sticky: assert property (p_timer_sticky) else $error("timer flag dropped"); // RULE_05

  property p_global_gate;
    @(posedge mclk) disable iff (reset)
      !global_irq_enable |=> !irq_request;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request without global"); // RULE_02

  property p_timer_request;
    @(posedge mclk) disable iff (reset)
      (global_irq_enable && timer_overflow_irq_enable && timer_overflow_flag)
      |=> irq_request;
  endproperty
  a_timer_request: assert property (p_timer_request) else $error("timer request lost"); // RULE_04

  property p_peripheral_gate;
    @(posedge mclk) disable iff (reset)
      (!peripheral_irq_enable && !(timer_overflow_irq_enable && timer_overflow_flag)
       && !(ext_pin_irq_enable && ext_pin_flag)
       && !(port_change_irq_enable && port_change_flag))
      |=> !irq_request;
  endproperty
  a_peripheral_gate: assert property (p_peripheral_gate) else $error("peripheral not gated"); // RULE_03

  property p_any_request;
    @(posedge mclk) disable iff (reset)
      (global_irq_enable && ((ext_pin_irq_enable && ext_pin_flag)
       || (peripheral_irq_enable && events.periph_pending)))
      |=> irq_request;
  endproperty
  a_any_request: assert property (p_any_request) else $error("request missing"); // RULE_11

  property p_mirror_write;
    @(posedge mclk) disable iff (reset)
      (bus_req.wr && bus_req.addr == cic_pkg::IC_ADDR_BANK3 && flag_set == '0)
      |=> interrupt_control == $past(bus_req.wdata);
  endproperty
  a_mirror_write: assert property (p_mirror_write) else $error("mirror write lost"); // RULE_09

  property p_mirror_read;
    @(posedge mclk) disable iff (reset)
      (bus_req.rd && bus_req.addr == cic_pkg::IC_ADDR_BANK2)
      |=> rdata == $past(interrupt_control);
  endproperty
  a_mirror_read: assert property (p_mirror_read) else $error("mirror read wrong"); // RULE_09

  property p_reset_value;
    @(posedge mclk) $fell(reset) |-> interrupt_control[cic_pkg::TIMER_FLAG_BIT:0] == '0
      || events.timer_overflow || events.ext_pin_edge;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("flags not cleared by reset"); // RULE_12

  // ---------------------------------------------------------------------------
  // further checks
  // ---------------------------------------------------------------------------
  // the pin flag is as sticky as the timer flag
  property p_ext_sticky;
    @(posedge mclk) disable iff (reset)
      (ext_pin_flag && !(bus_req.wr && hit_ic)) |=> ext_pin_flag;
  endproperty
  a_ext_sticky: assert property (p_ext_sticky) else $error("pin flag lost"); // RULE_06

  // and so is the change flag, whatever the pins do afterwards
  property p_change_sticky;
    @(posedge mclk) disable iff (reset)
      (port_change_flag && !(bus_req.wr && hit_ic)) |=> port_change_flag;
  endproperty
  a_change_sticky: assert property (p_change_sticky) else $error("change flag lost"); // RULE_07

  // with no event and no write the register holds still
  property p_hold;
    @(posedge mclk) disable iff (reset)
      (!(bus_req.wr && hit_ic) && flag_set == '0) |=> $stable(interrupt_control);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved on its own"); // RULE_05

  // a write lands through any mirror; bits an event sets that cycle are left out
  property p_write_lands;
    @(posedge mclk) disable iff (reset)
      (bus_req.wr && hit_ic)
      |=> (interrupt_control & ~$past(flag_set)) == ($past(bus_req.wdata) & ~$past(flag_set));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost"); // RULE_09

  // per-pin enables take a write whole
  property p_ioc_write;
    @(posedge mclk) disable iff (reset)
      (bus_req.wr && hit_ioc) |=> per_pin_change_enable == $past(bus_req.wdata);
  endproperty
  a_ioc_write: assert property (p_ioc_write) else $error("enable write lost"); // RULE_10

  // software can read back which pins take part
  property p_ioc_read;
    @(posedge mclk) disable iff (reset)
      (bus_req.rd && hit_ioc) |=> rdata == $past(per_pin_change_enable);
  endproperty
  a_ioc_read: assert property (p_ioc_read) else $error("enable read wrong"); // RULE_10

  // read data falls back to idle unless a mapped read was taken, so a stale
  // byte never looks like a fresh answer
  property p_read_idle;
    @(posedge mclk) disable iff (reset)
      !(bus_req.rd && (hit_ic || hit_ioc)) |=> rdata == cic_pkg::RD_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle"); // RULE_09

  // a pending, enabled change raises the request under the global gate
  property p_change_request;
    @(posedge mclk) disable iff (reset)
      (global_irq_enable && port_change_irq_enable && port_change_flag) |=> irq_request;
  endproperty
  a_change_request: assert property (p_change_request) else $error("change irq lost"); // RULE_07

  // no source both flagged and enabled means no request, whatever the gates say
  property p_no_source;
    @(posedge mclk) disable iff (reset)
      (!(timer_overflow_irq_enable && timer_overflow_flag)
       && !(ext_pin_irq_enable && ext_pin_flag)
       && !(port_change_irq_enable && port_change_flag)
       && !(peripheral_irq_enable && events.periph_pending))
      |=> !irq_request;
  endproperty
  a_no_source: assert property (p_no_source) else $error("request without source"); // RULE_11

endmodule

// ==== test/cic_core_model.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// core model: software side of the register port
// ---------------------------------------------------------------------------
module cic_core_model (
  // clock
  input  wire logic                        mclk,
  // register port
  output cic_pkg::cic_bus_req_s            bus_req,
  input  wire logic [cic_pkg::DATA_W-1:0]  rdata
);
  // idle port: strobes low, address parked on an unmapped place
  initial bus_req = '{addr: 9'h1ff, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

  // one write cycle; address and data flip once released so stray decoding shows
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // one read cycle; data is taken in the cycle after the strobe, and only there
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: bus_req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '{addr: ~a, wdata: ~bus_req.wdata, wr: 1'b0, rd: 1'b0};
    @(negedge mclk);
    d = rdata;
  endtask

  // old flags go first, so an enable never meets a stale event
  task automatic enable_clean(input logic [7:0] ctl);
    wr(cic_pkg::IC_ADDR_BANK0, 8'h00);
    wr(cic_pkg::IC_ADDR_BANK0, ctl);
  endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  // ---------------------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------------------
  logic                        mclk;
  logic                        reset;
  cic_pkg::cic_bus_req_s       bus_req;
  logic [cic_pkg::DATA_W-1:0]  rdata;
  cic_pkg::cic_events_s        events;
  logic [cic_pkg::PORT_W-1:0]  port_b_pins;
  logic                        irq_request;
  logic [cic_pkg::DATA_W-1:0]  interrupt_control;
  logic [7:0]                  d;
  logic [8:0]                  bank [4];
  int                          num_errors = 0;
  int                          n_tests = 0;

  cic_core dut (.mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .events(events), .port_b_pins(port_b_pins), .irq_request(irq_request),
    .interrupt_control(interrupt_control));
  cic_core_model core (.mclk(mclk), .bus_req(bus_req), .rdata(rdata));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one-cycle event pulse; flags are looked at once the taking edge has passed
  task automatic pulse(input logic [2:0] ev);
    @(posedge mclk);
    events <= cic_pkg::cic_events_s'(ev);
    @(posedge mclk);
    events <= cic_pkg::cic_events_s'(3'b000);
    @(negedge mclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk(interrupt_control, 8'h00);
    core.rd(bank[0], d);
    chk(d, 8'h00);
    core.rd(cic_pkg::IOC_ADDR, d);
    chk(d, 8'hf0);
    core.rd(9'h001, d);
    chk(d, 8'h00);
    core.wr(9'h001, 8'hff);
    cyc(1);
    chk(interrupt_control, 8'h00);
    cyc(1);
    chk(rdata, 8'h00);
    chk({7'h00, irq_request}, 8'h00);
  endtask

  // every mirror writes and reads the same storage
  task automatic t_mirror();
    for (int i = 0; i < 4; i++) begin
      core.wr(bank[i], 8'h08 << i);
      for (int j = 0; j < 4; j++) begin
        core.rd(bank[j], d);
        chk(d, 8'h08 << i);
      end
    end
  endtask

  // flags rise with every enable off and stay until software clears them
  task automatic t_flags();
    core.wr(bank[0], 8'h00);
    pulse(3'b100);
    chk(interrupt_control, 8'h04);
    pulse(3'b010);
    chk(interrupt_control, 8'h06);
    cyc(5);
    chk(interrupt_control, 8'h06);
    chk({7'h00, irq_request}, 8'h00);
    core.wr(bank[3], 8'h00);
    cyc(1);
    chk(interrupt_control, 8'h00);
    // an event in the very cycle of a clearing write still sets its flag
    fork
      core.wr(bank[2], 8'h00);
      pulse(3'b010);
    join
    chk(interrupt_control, 8'h02);
  endtask

  // timer, pin and peripheral sources against their own enables and the global gate
  task automatic t_gate();
    logic [2:0] ev [2]  = '{3'b100, 3'b010};
    logic [7:0] en [2]  = '{8'h20, 8'h10};
    logic [7:0] fl [2]  = '{8'h04, 8'h02};
    for (int i = 0; i < 2; i++) begin
      core.enable_clean(en[i]);
      pulse(ev[i]);
      cyc(1);
      chk({7'h00, irq_request}, 8'h00);
      core.wr(bank[1], 8'h80 | en[i] | fl[i]);
      cyc(2);
      chk({7'h00, irq_request}, 8'h01);
      core.wr(bank[2], 8'h80 | fl[i]);
      cyc(2);
      chk({7'h00, irq_request}, 8'h00);
      core.wr(bank[3], 8'h00);
    end
    @(posedge mclk);
    events.periph_pending <= 1'b1;
    core.wr(bank[0], 8'h80);
    cyc(2);
    chk({7'h00, irq_request}, 8'h00);
    core.wr(bank[0], 8'hc0);
    cyc(2);
    chk({7'h00, irq_request}, 8'h01);
    core.wr(bank[0], 8'h40);
    cyc(2);
    chk({7'h00, irq_request}, 8'h00);
    @(posedge mclk);
    events.periph_pending <= 1'b0;
    core.wr(bank[0], 8'h00);
  endtask

  // only pins with their change enable set can raise the change flag
  task automatic t_port();
    @(posedge mclk);
    port_b_pins <= 8'h01;
    cyc(4);
    chk(interrupt_control, 8'h00);
    @(posedge mclk);
    port_b_pins <= 8'h81;
    cyc(4);
    chk(interrupt_control, 8'h01);
    core.enable_clean(8'h88);
    cyc(2);
    chk({7'h00, irq_request}, 8'h00);
    core.wr(cic_pkg::IOC_ADDR, 8'h01);
    @(posedge mclk);
    port_b_pins <= 8'h80;
    cyc(4);
    chk(interrupt_control, 8'h89);
    chk({7'h00, irq_request}, 8'h01);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    bank = '{cic_pkg::IC_ADDR_BANK0, cic_pkg::IC_ADDR_BANK1,
             cic_pkg::IC_ADDR_BANK2, cic_pkg::IC_ADDR_BANK3};
    reset = 1'b1;
    events = cic_pkg::cic_events_s'(3'b000);
    port_b_pins = 8'h00;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    t_reset();
    t_mirror();
    t_flags();
    t_gate();
    t_port();
    end_of_test();
  end

  // the whole run needs under two hundred cycles; far beyond that is a hang
  initial begin
    #(50 * 3000);
    num_errors++;
    end_of_test();
  end
endmodule
